// File: hw/pcm_pkg.sv
// constants, codes and carriers of the pcm voice serial port
// assumes one core clock at CORE_HZ; shared by design and bench
package pcm_pkg;
  localparam int unsigned CORE_HZ       = 250_000_000;
  localparam int unsigned CORE_MHZ      = CORE_HZ / 1_000_000;
  localparam int unsigned SYNTH_REF_MHZ = 24;
  localparam int unsigned FRAME_HZ      = 8000;
  localparam int unsigned KHZ_128       = 128;
  localparam int unsigned KHZ_256       = 256;
  localparam int unsigned KHZ_512       = 512;
  // accumulator modulus on the low-rate path: steps are kHz of edge rate
  localparam logic [21:0] MOD_LOW       = 22'(CORE_HZ / 1000);
  localparam logic [11:0] FRAME_128     = 12'(KHZ_128 * 1000 / FRAME_HZ);
  localparam logic [11:0] FRAME_256     = 12'(KHZ_256 * 1000 / FRAME_HZ);
  localparam logic [11:0] FRAME_512     = 12'(KHZ_512 * 1000 / FRAME_HZ);
  localparam int unsigned SYNC_DIV      = 8;
  localparam logic [1:0]  RATE_256      = 2'h0;
  localparam logic [1:0]  RATE_128      = 2'h1;
  localparam logic [1:0]  RATE_512      = 2'h2;
  localparam logic [1:0]  FMT_13        = 2'h0;
  localparam logic [1:0]  FMT_16        = 2'h1;
  localparam logic [1:0]  FMT_8W        = 2'h2;
  localparam logic [1:0]  FMT_8N        = 2'h3;
  localparam logic [11:0] SYNC_LONG     = 12'h008;
  localparam logic [11:0] SYNC_LONG_EXT = 12'h010;
  localparam logic [3:0]  LAST_NARROW   = 4'h7;
  localparam logic [3:0]  LAST_WIDE     = 4'hf;
  localparam logic [11:0] SPAN_NARROW   = 12'h020;
  localparam logic [11:0] SPAN_WIDE     = 12'h040;
  localparam logic [3:0]  ALL_SLOTS     = 4'hf;
  localparam logic [3:0]  THREE_SLOTS   = 4'h7;
  localparam logic [11:0] BIT_CNT_RST   = 12'hfff;
  localparam logic [11:0] FRAME_LEN_RST = 12'hfff;
  localparam logic [21:0] ACC_RST       = 22'h00_0000;

  typedef enum logic [1:0] {PAD_SIGN, PAD_ZERO, PAD_ATTEN} pad_t;

  typedef struct packed {
    logic       slave_mode;
    logic       short_sync;
    pad_t       pad_mode;
    logic [2:0] atten_code;
    logic       lsb_first;
    logic       tx_tristate;
    logic       tristate_rise;
    logic       sync_suppress;
    logic       gci_mode;
    logic       mute;
    logic       high_rate_synth_select;
    logic       long_sync_len;
    logic [1:0] master_clk_rate;
    logic [3:0] active_slot;
    logic [1:0] sample_format;
  } pcm_cfg_t;

  typedef struct packed {
    logic [7:0]  sync_limit;
    logic [7:0]  clk_step_increment;
    logic [12:0] clk_step_modulus;
  } low_jitter_synth_key_t;

  typedef struct packed {
    logic [1:0]  slot;
    logic [15:0] data;
  } voice_word_t;
endpackage

// File: hw/pcm_voice_serial_port.sv
// pcm voice serial port: master/slave framing, slots, formats, pins
// assumes tx samples are steady around tx_take and pins are async
// Overview of operation
// RULE1: master bit clock runs at 128, 256 or 512 kHz.
// RULE2: slave accepts an external bit clock up to 2048 kHz.
// RULE3: 13-bit, 16-bit linear and 8-bit companded samples at 8 ksamples/s.
// RULE4: at most three links, each on one of the first four slots.
// RULE5: master drives bit clock and sync; slave takes both from outside.
// RULE6: long sync: rising sync edge marks the start of a word.
// RULE7: long sync master holds sync high for 8 bit clocks.
// RULE8: slave long sync lasts two falling edges up to 62.5 us.
// RULE9: input sampled on falling edges, output launched on rising edges.
// RULE10: optional output release after last active bit, on fall or next rise.
// RULE11: short sync: falling sync edge starts word, pulse one bit clock.
// RULE12: gci mode gives access to both 64 kbit/s b channels.
// RULE13: gci frame starts on rising sync at 8 kHz; slave clock to 4.096 MHz.
// RULE14: slots span 8 or 16 clocks; 8-clock slots only for 8-bit samples. Code also uses 8-clock slots in gci mode for any sample format.
// RULE15: bit order selectable, msb first or lsb first.
// RULE16: unused bits of 16-clock slots: sign, zeros or 3-bit attenuation.
// RULE17: mute drives the serial output as zero.
// RULE18: sync suppression holds master sync low, bit clock keeps running.
// RULE19: low-rate synthesis limits clock to 128/256/512 kHz, sync to 8 kHz.
// RULE20: high-rate synthesis with long sync: sync length 8 or 16 clocks.
// RULE21: high-rate bit clock equals increment over modulus times 24 MHz.
// RULE22: high-rate sync equals bit clock over eight times sync divider.
`timescale 1ns/1ns
module pcm_voice_serial_port (
  // clock, reset, enable
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          ce,
  // configuration
  input  wire pcm_pkg::pcm_cfg_t             cfg,
  input  wire pcm_pkg::low_jitter_synth_key_t jit,
  // voice samples
  input  wire logic [3:0][15:0]              tx_sample,
  output logic                               tx_take,
  output logic [1:0]                         tx_slot,
  output pcm_pkg::voice_word_t               rx_word,
  output logic                               rx_valid,
  // pins
  input  wire logic                          pcm_clk_in,
  input  wire logic                          pcm_sync_in,
  input  wire logic                          pcm_in,
  output logic                               pcm_clk_out,
  output logic                               pcm_clk_oe,
  output logic                               pcm_sync_out,
  output logic                               pcm_sync_oe,
  output logic                               pcm_out,
  output logic                               pcm_out_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [21:0] acc, step, modulus, acc_sum;
  logic        wrap, rise_ev, fall_ev, slave, narrow;
  logic        clk_s1, clk_s2, clk_d, sync_s1, sync_s2, din_s1, din_s2;
  logic        sync_prev, restart, start_long, start_short, framed;
  logic [11:0] bit_cnt, next_bit, frame_len, master_len, learn_len;
  logic [11:0] sync_len, after_bit, rx_pos;
  logic [3:0]  mask, last;
  logic [6:0]  lc, cc, fc;
  logic        nx_act, cur_act, fol_act, release_early;
  logic [15:0] fresh, tx_hold, tx_src, rx_shift, rx_with;
  logic [3:0]  tidx, ridx;

  assign slave  = cfg.slave_mode;
  assign narrow = cfg.gci_mode || cfg.sample_format == pcm_pkg::FMT_8N; // [RULE14] [RULE12]
  assign last   = narrow ? pcm_pkg::LAST_NARROW : pcm_pkg::LAST_WIDE;
  // a fourth slot bit is dropped so no more than three links run
  assign mask   = cfg.active_slot &
                  ((cfg.active_slot == pcm_pkg::ALL_SLOTS) ? pcm_pkg::THREE_SLOTS
                                                           : pcm_pkg::ALL_SLOTS); // [RULE4]

  // step and modulus of the clock synthesiser
  always_comb begin
    if (cfg.high_rate_synth_select) begin
      step       = 22'(jit.clk_step_increment * (2 * pcm_pkg::SYNTH_REF_MHZ)); // [RULE21]
      modulus    = 22'(jit.clk_step_modulus * pcm_pkg::CORE_MHZ); // [RULE21]
      master_len = 12'(jit.sync_limit * pcm_pkg::SYNC_DIV); // [RULE22]
    end else begin
      modulus = pcm_pkg::MOD_LOW;
      case (cfg.master_clk_rate) // [RULE1] [RULE19]
        pcm_pkg::RATE_128: begin
          step       = 22'(2 * pcm_pkg::KHZ_128);
          master_len = pcm_pkg::FRAME_128;
        end
        pcm_pkg::RATE_512: begin
          step       = 22'(2 * pcm_pkg::KHZ_512);
          master_len = pcm_pkg::FRAME_512;
        end
        default: begin
          step       = 22'(2 * pcm_pkg::KHZ_256);
          master_len = pcm_pkg::FRAME_256;
        end
      endcase
    end
  end

  assign acc_sum = acc + step;
  assign wrap    = !slave && modulus != 22'h00_0000 && acc_sum >= modulus;

  // each wrap of the accumulator is one half period of the bit clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc         <= pcm_pkg::ACC_RST;
      pcm_clk_out <= 1'b0;
    end else if (ce) begin
      if (slave) begin
        acc         <= pcm_pkg::ACC_RST;
        pcm_clk_out <= 1'b0;
      end else if (wrap) begin
        acc         <= acc_sum - modulus;
        pcm_clk_out <= ~pcm_clk_out; // [RULE5]
      end else if (modulus != 22'h00_0000) begin
        acc <= acc_sum;
      end
    end
  end

  // pin synchronisers; core clock is far above the 4.096 MHz slave limit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {clk_s1, clk_s2, clk_d}    <= 3'h0;
      {sync_s1, sync_s2, din_s1} <= 3'h0;
      din_s2                     <= 1'b0;
    end else if (ce) begin
      clk_s1  <= pcm_clk_in; // [RULE2] [RULE13]
      clk_s2  <= clk_s1;
      clk_d   <= clk_s2;
      sync_s1 <= pcm_sync_in;
      sync_s2 <= sync_s1;
      din_s1  <= pcm_in;
      din_s2  <= din_s1;
    end
  end

  assign rise_ev = slave ? (clk_s2 && !clk_d) : (wrap && !pcm_clk_out);
  assign fall_ev = slave ? (!clk_s2 && clk_d) : (wrap && pcm_clk_out);

  // slave frame start, judged at falling edges
  assign start_long  = slave && !cfg.short_sync && sync_s2 && !sync_prev; // [RULE6] [RULE8] [RULE13]
  assign start_short = slave && cfg.short_sync && sync_s2; // [RULE11]

  assign frame_len = slave ? learn_len : master_len;
  assign next_bit  = (restart || bit_cnt >= frame_len - 12'h001) ? 12'h000
                                                                : bit_cnt + 12'h001;
  assign after_bit = bit_cnt + 12'h001;

  // bit position in frame; the slave learns the frame length from the sync
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bit_cnt   <= pcm_pkg::BIT_CNT_RST;
      learn_len <= pcm_pkg::FRAME_LEN_RST;
      restart   <= 1'b0;
      framed    <= 1'b0;
      // high so a sync already high at release is not taken as a start
      sync_prev <= 1'b1;
    end else if (ce) begin
      if (rise_ev) begin
        bit_cnt <= next_bit;
        restart <= 1'b0;
      end else if (fall_ev) begin
        sync_prev <= sync_s2;
        if (start_long) begin
          bit_cnt <= 12'h000;
          framed  <= 1'b1;
          // the partial run before the first start would teach a wrong length
          if (framed && bit_cnt != 12'h000)
            learn_len <= bit_cnt;
        end else if (start_short) begin
          restart <= 1'b1; // next rising edge launches bit 0
          framed  <= 1'b1;
          if (framed)
            learn_len <= after_bit;
        end
      end
    end
  end

  function automatic logic [6:0] locate(input logic [11:0] b, input logic nar);
    locate = nar ? {b < pcm_pkg::SPAN_NARROW, b[4:3], 1'b0, b[2:0]}
                 : {b < pcm_pkg::SPAN_WIDE, b[5:4], b[3:0]};
  endfunction

  // a slave start fall is bit 0 although the counter still holds the old count
  assign rx_pos  = start_long ? 12'h000 : bit_cnt;
  assign lc      = locate(next_bit, narrow);
  assign cc      = locate(rx_pos, narrow);
  assign fc      = locate(after_bit, narrow);
  // a slave stays silent until it has seen a frame start
  assign nx_act  = (!slave || framed) && lc[6] && mask[lc[5:4]];
  assign cur_act = (!slave || framed || start_long) && cc[6] && mask[cc[5:4]];
  assign fol_act = after_bit < frame_len && fc[6] && mask[fc[5:4]];
  assign tidx    = cfg.lsb_first ? lc[3:0] : last - lc[3:0]; // [RULE15]
  assign ridx    = cfg.lsb_first ? cc[3:0] : last - cc[3:0]; // [RULE15]

  // slot word from a sample: sign and zero padding sit on the msb side, attenuation padding on the lsb side
  always_comb begin
    logic [15:0] s;
    s = tx_sample[lc[5:4]];
    case (cfg.sample_format) // [RULE3] [RULE16]
      pcm_pkg::FMT_13:
        case (cfg.pad_mode)
          pcm_pkg::PAD_SIGN:  fresh = {{3{s[12]}}, s[12:0]};
          pcm_pkg::PAD_ATTEN: fresh = {s[12:0], cfg.atten_code};
          default:            fresh = {3'h0, s[12:0]};
        endcase
      pcm_pkg::FMT_16: fresh = s;
      pcm_pkg::FMT_8W:
        case (cfg.pad_mode)
          pcm_pkg::PAD_SIGN:  fresh = {{8{s[7]}}, s[7:0]};
          pcm_pkg::PAD_ATTEN: fresh = {s[7:0], 5'h00, cfg.atten_code};
          default:            fresh = {8'h00, s[7:0]};
        endcase
      default: fresh = {8'h00, s[7:0]};
    endcase
  end

  assign tx_src        = (lc[3:0] == 4'h0) ? fresh : tx_hold;
  assign release_early = cfg.tx_tristate && !cfg.tristate_rise && cur_act &&
                         cc[3:0] == last && !fol_act;

  // transmit: launched on rising edges only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_hold    <= 16'h0000;
      tx_take    <= 1'b0;
      tx_slot    <= 2'h0;
      pcm_out    <= 1'b0;
      pcm_out_oe <= 1'b0;
    end else if (ce) begin
      tx_take <= 1'b0;
      if (rise_ev) begin
        if (nx_act) begin
          if (lc[3:0] == 4'h0) begin
            tx_hold <= fresh;
            tx_take <= 1'b1;
            tx_slot <= lc[5:4];
          end
          pcm_out    <= cfg.mute ? 1'b0 : tx_src[tidx]; // [RULE9] [RULE17]
          pcm_out_oe <= 1'b1;
        end else begin
          pcm_out    <= 1'b0;
          pcm_out_oe <= !cfg.tx_tristate; // [RULE10]
        end
      end else if (fall_ev && release_early) begin
        pcm_out_oe <= 1'b0; // [RULE10]
      end
    end
  end

  always_comb begin
    rx_with       = rx_shift;
    rx_with[ridx] = din_s2;
  end

  // receive: sampled on falling edges, word handed over at the last bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_shift <= 16'h0000;
      rx_word  <= '0;
      rx_valid <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (fall_ev && cur_act) begin
        rx_shift <= rx_with; // [RULE9]
        if (cc[3:0] == last) begin
          rx_valid     <= 1'b1;
          rx_word.slot <= cc[5:4];
          case (cfg.sample_format) // [RULE3] [RULE16]
            pcm_pkg::FMT_13:
              rx_word.data <= (cfg.pad_mode == pcm_pkg::PAD_ATTEN)
                              ? {{3{rx_with[15]}}, rx_with[15:3]}
                              : {{3{rx_with[12]}}, rx_with[12:0]};
            pcm_pkg::FMT_16: rx_word.data <= rx_with;
            pcm_pkg::FMT_8W:
              rx_word.data <= (cfg.pad_mode == pcm_pkg::PAD_ATTEN)
                              ? {8'h00, rx_with[15:8]} : {8'h00, rx_with[7:0]};
            default: rx_word.data <= {8'h00, rx_with[7:0]};
          endcase
        end
      end
    end
  end

  // long sync is 16 clocks only on the high-rate path when asked
  assign sync_len = (cfg.high_rate_synth_select && cfg.long_sync_len)
                    ? pcm_pkg::SYNC_LONG_EXT : pcm_pkg::SYNC_LONG; // [RULE20]

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pcm_sync_out <= 1'b0;
      pcm_sync_oe  <= 1'b0;
      pcm_clk_oe   <= 1'b0;
    end else if (ce) begin
      pcm_sync_oe <= !slave; // [RULE5]
      pcm_clk_oe  <= !slave; // [RULE5]
      if (slave || cfg.sync_suppress) begin
        pcm_sync_out <= 1'b0; // [RULE18]
      end else if (rise_ev) begin
        if (cfg.short_sync && !cfg.gci_mode)
          pcm_sync_out <= next_bit == frame_len - 12'h001; // [RULE11]
        else
          pcm_sync_out <= next_bit < sync_len; // [RULE7] [RULE6] [RULE13]
      end
    end
  end

  // helper: core cycles since the last bit clock edge
  localparam int HALF_MIN = pcm_pkg::CORE_HZ / (2 * pcm_pkg::KHZ_512 * 1000) - 1;
  localparam int HALF_MAX = HALF_MIN + 1;
  logic [11:0] half_cnt;
  logic        half_seen, mode512;
  assign mode512 = !slave && !cfg.high_rate_synth_select &&
                   cfg.master_clk_rate == pcm_pkg::RATE_512;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !mode512) begin
      half_cnt  <= 12'h000;
      half_seen <= 1'b0;
    end else if (ce && wrap) begin
      half_cnt  <= 12'h000;
      half_seen <= 1'b1;
    end else if (ce) begin
      half_cnt <= half_cnt + 12'h001;
    end
  end

  chk_clk_half_period: assert property ( // [RULE1]
    wrap && ce && mode512 && half_seen |-> half_cnt inside {[HALF_MIN:HALF_MAX]})
    else $error("bit clock half period off at 512 kHz");
  chk_slave_pins_free: assert property ( // [RULE5]
    $past(slave) |-> !pcm_clk_oe && !pcm_sync_oe)
    else $error("pins driven in slave mode");
  chk_mute_zero_out: assert property ( // [RULE17]
    ce && rise_ev && cfg.mute |=> !pcm_out)
    else $error("output not zero while muted");
  chk_sync_suppressed: assert property ( // [RULE18]
    ce && cfg.sync_suppress |=> !pcm_sync_out)
    else $error("sync not held low while suppressed");
  chk_long_sync_start: assert property ( // [RULE7]
    !slave && !cfg.short_sync && $rose(pcm_sync_out) |-> bit_cnt == 12'h000)
    else $error("long sync rise not at bit 0");
  chk_short_sync_one: assert property ( // [RULE11]
    !slave && cfg.short_sync && !cfg.gci_mode && $rose(pcm_sync_out)
    |-> bit_cnt == frame_len - 12'h001)
    else $error("short sync not in last bit of frame");
  chk_out_on_rise: assert property ( // [RULE9]
    $changed(pcm_out) |-> $past(rise_ev))
    else $error("output changed away from a rising edge");
  chk_rx_on_fall: assert property ( // [RULE9]
    rx_valid |-> $past(fall_ev) && $past(cur_act))
    else $error("word received away from a falling edge");
  chk_link_count: assert property ( // [RULE4]
    tx_take |-> cfg.active_slot[tx_slot] &&
                !(cfg.active_slot == pcm_pkg::ALL_SLOTS && tx_slot == 2'h3))
    else $error("more than three slots active");
  chk_release_edge: assert property ( // [RULE10]
    $fell(pcm_out_oe) |-> $past(cfg.tx_tristate) && $past(rise_ev || fall_ev))
    else $error("output released without tristate option or edge");
endmodule

// File: dv/pcm_codec_model.sv
// codec model on the far side of the pcm pins: drives pcm_in, captures pcm_out
// assumes long sync framing; makes clock and sync itself only while gen is high
`timescale 1ns/1ns
module pcm_codec_model (
  // far-side controls
  input  wire logic        gen,
  input  wire logic [7:0]  pat,
  input  wire logic [3:0]  last,
  // device pins
  input  wire logic        clk_out,
  input  wire logic        clk_oe,
  input  wire logic        sync_out,
  input  wire logic        sync_oe,
  input  wire logic        dout,
  output logic             clk_in,
  output logic             sync_in,
  output logic             din,
  // captured slot 0
  output logic [15:0]      cap,
  output int               cap_cnt
);
  logic gclk  = 1'b0;
  logic gsync = 1'b0;
  logic ps_r  = 1'b0;
  logic ps_f  = 1'b0;
  int   gbit  = 0;
  int   k     = 99;
  int   idx   = 99;
  assign clk_in  = clk_oe ? clk_out : gclk;
  assign sync_in = sync_oe ? sync_out : gsync;
  initial begin
    din     = 1'b0;
    cap     = 16'h0000;
    cap_cnt = 0;
  end
  // 2016 kHz slave clock, stands still when not generating
  always #248 if (gen) gclk = ~gclk;
  // 32-bit frame, sync high 8 bits: well under half a frame
  always @(posedge gclk) begin
    gbit  = (gbit + 1) % 32;
    gsync = (gbit < 8);
  end
  // launch on rises; outside the slot the line keeps toggling, never a stale bit
  always @(posedge clk_in) begin
    #1;
    k    = (sync_in && !ps_r) ? 0 : k + (k < 99);
    ps_r = sync_in;
    din  = (k < 8) ? pat[7 - k] : ~din;
  end
  always @(negedge clk_in) begin
    idx  = (sync_in && !ps_f) ? 0 : idx + (idx < 99);
    ps_f = sync_in;
    if (idx < 16) cap = {cap[14:0], dout};
    if (idx == int'(last)) cap_cnt++;
  end
endmodule

// File: dv/pcm_voice_serial_port_tb.sv
// self-checking bench of the pcm voice serial port
// assumes pcm_pkg and the codec model are compiled first
`timescale 1ns/1ns
module pcm_voice_serial_port_tb;
  logic                           core_clk  = 1'b0;
  logic                           sys_rst   = 1'b1;
  pcm_pkg::pcm_cfg_t              cfg       = '0;
  pcm_pkg::pcm_cfg_t              nc;
  pcm_pkg::low_jitter_synth_key_t jit       = {8'h04, 8'h01, 13'h0006};
  logic [3:0][15:0]               tx_sample = '0;
  pcm_pkg::voice_word_t           rx_word;
  logic [1:0]                     tx_slot;
  logic                           tx_take, rx_valid, pcm_clk_in, pcm_sync_in, pcm_in;
  logic                           pcm_clk_out, pcm_clk_oe, pcm_sync_out, pcm_sync_oe;
  logic                           pcm_out, pcm_out_oe;
  logic                           gen  = 1'b0;
  logic [7:0]                     pat  = 8'ha6;
  logic [3:0]                     last = 4'h7;
  logic [15:0]                    cap;
  int                             cap_cnt, n, hi, len;
  int                             err_total = 0;
  int                             cmp_count = 0;

  pcm_voice_serial_port dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1), .cfg(cfg),
    .jit(jit), .tx_sample(tx_sample), .tx_take(tx_take), .tx_slot(tx_slot), .rx_word(rx_word),
    .rx_valid(rx_valid), .pcm_clk_in(pcm_clk_in), .pcm_sync_in(pcm_sync_in), .pcm_in(pcm_in),
    .pcm_clk_out(pcm_clk_out), .pcm_clk_oe(pcm_clk_oe), .pcm_sync_out(pcm_sync_out),
    .pcm_sync_oe(pcm_sync_oe), .pcm_out(pcm_out), .pcm_out_oe(pcm_out_oe));
  pcm_codec_model codec (.gen(gen), .pat(pat), .last(last), .clk_out(pcm_clk_out),
    .clk_oe(pcm_clk_oe), .sync_out(pcm_sync_out), .sync_oe(pcm_sync_oe), .dout(pcm_out),
    .clk_in(pcm_clk_in), .sync_in(pcm_sync_in), .din(pcm_in), .cap(cap), .cap_cnt(cap_cnt));

  initial forever #2 core_clk = ~core_clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bail(input string what);
    err_total++;
    $display("ERROR %s expected event seen none", what);
    summarize();
  endtask
  function automatic pcm_pkg::pcm_cfg_t base();
    pcm_pkg::pcm_cfg_t c;
    c = '0;
    c.high_rate_synth_select = 1'b1;
    c.active_slot = 4'h1;
    c.sample_format = pcm_pkg::FMT_8N;
    return c;
  endfunction
  // every scenario restarts from reset so frame phase is known
  task automatic restart();
    @(negedge core_clk);
    cfg = nc;
    sys_rst = 1'b1;
    repeat (12) @(negedge core_clk);
    check("clock drive in reset", pcm_clk_oe, 1'b0);
    sys_rst = 1'b0;
  endtask
  task automatic rise();
    logic p;
    n = 0;
    do begin
      p = pcm_clk_out;
      @(negedge core_clk);
      n++;
      if (n > 4000) bail("bit clock rise");
    end while (!(p === 1'b0 && pcm_clk_out === 1'b1));
  endtask
  // hi = bits with sync high, len = bits from one frame start to the next
  task automatic frame();
    logic lo;
    len = 0;
    do begin
      rise();
      len++;
    end while (pcm_sync_out !== 1'b0 && len < 80);
    do begin
      rise();
      len++;
    end while (pcm_sync_out !== 1'b1 && len < 80);
    if (len >= 80) bail("frame sync");
    hi = 0;
    len = 0;
    lo = 1'b0;
    do begin
      hi += (pcm_sync_out === 1'b1);
      len++;
      rise();
      lo |= (pcm_sync_out === 1'b0);
    end while (!(lo && pcm_sync_out === 1'b1) && len < 80);
  endtask
  task automatic wait_cap();
    int c0;
    c0 = cap_cnt;
    for (int i = 0; cap_cnt == c0; i++) begin
      if (i > 20000) bail("captured slot");
      @(negedge core_clk);
    end
  endtask
  task automatic wait_flag(input bit take);
    for (int i = 0; i <= 40000; i++) begin
      @(negedge core_clk);
      if ((take ? tx_take : rx_valid) === 1'b1) return;
    end
    bail(take ? "sample take" : "receive word");
  endtask

  task automatic t_high(input bit ext, input bit short);
    int e;
    nc = base();
    nc.long_sync_len = ext;
    nc.short_sync = short;
    restart();
    @(negedge core_clk);
    check("master clock drive", pcm_clk_oe & pcm_sync_oe, 1'b1);
    rise();
    rise();
    e = pcm_pkg::CORE_MHZ * int'(jit.clk_step_modulus);
    e = e / (pcm_pkg::SYNTH_REF_MHZ * int'(jit.clk_step_increment));
    check("high rate period", n == e || n == e + 1, 1'b1);
    frame();
    check("sync high bits", hi, short ? 1 : (ext ? 16 : 8));
    check("frame bits", len, 8 * int'(jit.sync_limit));
  endtask
  task automatic t_low(input logic [1:0] rate, input int khz);
    int e;
    nc = base();
    nc.high_rate_synth_select = 1'b0;
    nc.master_clk_rate = rate;
    restart();
    rise();
    rise();
    e = pcm_pkg::CORE_HZ / (khz * 1000);
    check("low rate period", n == e || n == e + 1, 1'b1);
  endtask
  task automatic t_word(input bit lsb, input bit mute, input logic [7:0] etx, input logic [7:0] erx);
    nc = base();
    nc.lsb_first = lsb;
    nc.mute = mute;
    tx_sample[0] = 16'h00c5;
    last = 4'h7;
    restart();
    wait_cap();
    wait_cap();
    check("sent slot", cap[7:0], etx);
    wait_flag(1'b0);
    check("received word", rx_word, {2'h0, 8'h00, erx});
  endtask
  task automatic t_pad(input logic [1:0] fm, input pcm_pkg::pad_t pm, input logic [15:0] exp);
    nc = base();
    nc.sample_format = fm;
    nc.pad_mode = pm;
    nc.atten_code = 3'h5;
    tx_sample[0] = 16'h1085;
    last = 4'hf;
    restart();
    wait_cap();
    wait_cap();
    check("padded slot", cap, exp);
  endtask
  task automatic t_slots(input bit gci, input logic [3:0] act, input logic [7:0] seq);
    nc = base();
    nc.gci_mode = gci;
    nc.active_slot = act;
    restart();
    for (int i = 0; i < 4; i++) begin
      wait_flag(1'b1);
      check("slot taken", tx_slot, seq[2*i +: 2]);
    end
    frame();
    check("frame sync bits", hi, 8);
  endtask
  task automatic t_tri(input bit on_rise);
    nc = base();
    nc.tx_tristate = 1'b1;
    nc.tristate_rise = on_rise;
    last = 4'h7;
    restart();
    wait_cap();
    repeat (2) @(negedge core_clk);
    check("drive after last fall", pcm_out_oe, on_rise);
    rise();
    repeat (2) @(negedge core_clk);
    check("drive in idle slot", pcm_out_oe, 1'b0);
  endtask
  task automatic t_suppress();
    nc = base();
    nc.sync_suppress = 1'b1;
    restart();
    hi = 0;
    for (int i = 0; i < 40; i++) begin
      rise();
      hi += (pcm_sync_out !== 1'b0);
    end
    check("suppressed sync", hi, 0);
  endtask
  task automatic t_slave();
    nc = base();
    nc.slave_mode = 1'b1;
    gen = 1'b1;
    restart();
    wait_flag(1'b0);
    wait_flag(1'b0);
    check("slave received word", rx_word, {2'h0, 8'h00, pat});
    check("slave pin drive", pcm_clk_oe | pcm_sync_oe, 1'b0);
    gen = 1'b0;
  endtask

  initial begin
    t_high(1'b0, 1'b0);
    t_high(1'b1, 1'b0);
    t_high(1'b0, 1'b1);
    t_low(pcm_pkg::RATE_128, pcm_pkg::KHZ_128);
    t_low(pcm_pkg::RATE_256, pcm_pkg::KHZ_256);
    t_low(pcm_pkg::RATE_512, pcm_pkg::KHZ_512);
    t_word(1'b0, 1'b0, 8'hc5, 8'ha6);
    t_word(1'b1, 1'b0, 8'ha3, 8'h65);
    t_word(1'b0, 1'b1, 8'h00, 8'ha6);
    t_pad(pcm_pkg::FMT_8W, pcm_pkg::PAD_SIGN, 16'hff85);
    t_pad(pcm_pkg::FMT_8W, pcm_pkg::PAD_ZERO, 16'h0085);
    t_pad(pcm_pkg::FMT_8W, pcm_pkg::PAD_ATTEN, 16'h8505);
    t_pad(pcm_pkg::FMT_13, pcm_pkg::PAD_SIGN, 16'hf085);
    t_slots(1'b0, 4'hf, 8'h24);
    t_slots(1'b1, 4'h3, 8'h44);
    t_tri(1'b0);
    t_tri(1'b1);
    t_suppress();
    t_slave();
    summarize();
  end
endmodule
